// ---- dv/flash_dev_model.sv ----
// behavioural flash device answering the host pins
`timescale 1ns/10ps
module flash_dev_model import flash_host_pkg::*; #(
  parameter logic [7:0] MFR = 8'h5A, // arbitrary value
  parameter logic [7:0] DEV = 8'h3C  // arbitrary value
) (
  // host pins
  input  wire bus_pins_s   pins,
  input  wire logic        hv_sel,
  input  wire logic        rst_pin_n,
  input  wire logic        rst_hv,
  output logic [15:0]      dq_in
);
  logic [15:0]  mem [logic [19:0]];
  logic [15:0]  smem [logic [7:0]];
  logic [255:0] prot = '0;
  logic         map = 0, slock = 0, idm = 0, order_bad = 0, pv = 0;
  logic [1:0]   seq = 0;
  logic [15:0]  rv, last = 16'h0000;
  wire          rd = !pins.ce_n && !pins.oe_n;
  wire [19:0]   a = pins.addr;
  wire [15:0]   d = pins.dq;
  // id codes and status first, then mapped region, then array
  // pins in the list: a read after a write to the same address must see fresh data
  always @(pins or a or hv_sel or rst_hv or idm or map or slock or prot or pv) begin
    if (hv_sel || idm || pv || (rst_hv && a[1]))
      rv = a[1] ? {15'h0000, map ? slock : prot[a[19:12]]} : {8'h00, a[0] ? DEV : MFR};
    else if (map && a[19:12] == 8'h00)
      rv = smem.exists(a[7:0]) ? smem[a[7:0]] : 16'hFFFF;
    else
      rv = mem.exists(a) ? mem[a] : 16'hFFFF;
  end
  // a released bus shows the inverse so stale data cannot pass
  always @(negedge rd) begin
    last = ~rv;
    pv = 0;
  end
  assign dq_in = !pins.dq_oe_n ? d : rd ? rv : last;
  // hardware reset drops region mapping and id mode
  always @(negedge rst_pin_n) begin
    map = 0;
    idm = 0;
  end
  // writes land on the rising write strobe; codes match host defaults
  always @(posedge pins.we_n) if (!pins.ce_n) begin
    // region protect may run with the reset pin at normal high; next read verifies
    if ((rst_hv || map) && d == 16'h0077) begin
      pv = 1;
      if (map) slock = 1;
      else prot[a[19:12]] = 1;
    end else if (rst_hv && d == 16'h0088) begin
      if (~&prot) order_bad = 1;
      prot = '0;
    end else if (seq == 2'h2 && a == 20'h00001) begin
      idm = d == 16'h0033;
      if (d == 16'h0044) map = 1;
      if (d == 16'h0055) map = 0;
      seq = 0;
    end else if (seq == 2'h1 && a == 20'h00002 && d == 16'h0022) seq = 2;
    else if (a == 20'h00001 && d == 16'h0011) seq = 1;
    else begin
      seq = 0;
      if (d == 16'h0066) idm = 0;
      else if (map && a[19:12] == 8'h00) begin
        if (!slock) smem[a[7:0]] = d;
      end else if (!prot[a[19:12]] || rst_hv) mem[a] = d;
    end
  end
endmodule

// ---- dv/flash_host_tb.sv ----
// self-checking bench for the flash id and protection host
`timescale 1ns/10ps
module flash_host_tb;
  import flash_host_pkg::*;
  localparam logic [7:0] MFR = 8'h5A; // arbitrary value
  localparam logic [7:0] DEV = 8'h3C; // arbitrary value
  logic sys_clk = 0, reset_n = 0, cmd_valid = 0, byte_mode = 0;
  logic cmd_ready, resp_valid, secure_mapped, temp_unprot, hv_sel, rst_pin_n, rst_hv;
  logic [15:0] dq_in;
  cmd_s        cmd = '0;
  resp_s       resp;
  bus_pins_s   pins;
  int          error_cnt = 0, checks_done = 0;
  // short waits keep the unprotect prepass brief
  flash_host #(.PROT_WAIT(20), .UNPROT_WAIT(30), .MAX_TRIES(3)) uut (.sys_clk(sys_clk),
    .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
    .byte_mode(byte_mode), .sec_prot_hv(1'b0), .resp_valid(resp_valid), .resp(resp),
    .secure_mapped(secure_mapped), .temp_unprot(temp_unprot), .pins(pins), .dq_in(dq_in),
    .hv_select_addr_pin_en(hv_sel), .reset_pin_n(rst_pin_n), .reset_hv_en(rst_hv));
  flash_dev_model #(.MFR(MFR), .DEV(DEV)) u_dev (.pins(pins), .hv_sel(hv_sel),
    .rst_pin_n(rst_pin_n), .rst_hv(rst_hv), .dq_in(dq_in));
  always #5 sys_clk = ~sys_clk;
  task automatic chk(input string nm, input logic [15:0] e, g);
    checks_done++;
    if (g !== e) begin
      $display("[ERR] %s exp %h got %h", nm, e, g);
      error_cnt++;
    end
  endtask
  // one request, then wait for its answer pulse
  task automatic op(input op_e o, input logic [19:0] a, input logic [15:0] d = 16'h0000,
                    input logic [1:0] s = 2'h0);
    int n;
    n = 0;
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd = '{op: o, sel: s, addr: a, data: d};
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    do begin
      @(posedge sys_clk);
      #1 n++;
    end while (resp_valid !== 1'b1 && n < 90000);
    if (n >= 90000) chk("resp_valid", 16'h0001, 16'h0000);
  endtask
  task automatic wr_rd(input string nm, input logic [19:0] a, input logic [15:0] d, e);
    op(OP_WRITE, a, d);
    op(OP_READ, a);
    chk(nm, e, resp.data);
  endtask
  task automatic t_id;
    for (int s = 0; s < 3; s++) begin
      op(OP_ID_HV, 20'h05000, 16'h0000, 2'(s));
      chk("id_hv", {8'h00, s == 0 ? MFR : s == 1 ? DEV : 8'h00}, resp.data);
    end
    op(OP_ID_CMD, 20'h00000, 16'h0000, 2'h1);
    chk("id_cmd", {8'h00, DEV}, resp.data);
  endtask
  task automatic t_prot;
    op(OP_WRITE, 20'h05010, 16'h1234);
    op(OP_PROTECT, 20'h05000);
    chk("prot_ok", 16'h0003, {14'h0000, resp.ok, resp.prot});
    op(OP_ID_HV, 20'h05000, 16'h0000, 2'h2);
    chk("prot", 16'h0001, resp.data);
    chk("lock", 16'h0000, {15'h0000, resp.lock});
    wr_rd("prot_wr", 20'h05010, 16'h5678, 16'h1234);
    op(OP_TEMP_ON, 20'h05000);
    chk("temp", 16'h0001, {15'h0000, temp_unprot});
    wr_rd("temp_wr", 20'h05010, 16'h5678, 16'h5678);
    op(OP_TEMP_OFF, 20'h05000);
    chk("temp_clr", 16'h0000, {15'h0000, temp_unprot});
    wr_rd("temp_off", 20'h05010, 16'h9ABC, 16'h5678);
    op(OP_UNPROTECT, 20'h05000);
    chk("unprot_ok", 16'h0002, {14'h0000, resp.ok, resp.prot});
    chk("order", 16'h0000, {15'h0000, u_dev.order_bad});
    wr_rd("unprot_wr", 20'h05010, 16'h9ABC, 16'h9ABC);
  endtask
  task automatic t_sec;
    op(OP_SEC_ENTER, 20'h00000);
    chk("mapped", 16'h0001, {15'h0000, secure_mapped});
    wr_rd("sec_wr", 20'h00010, 16'hA5A5, 16'hA5A5);
    op(OP_READ, 20'h00080);
    chk("end_w", 16'h0001, {15'h0000, resp.err});
    @(negedge sys_clk);
    byte_mode = 1'b1;
    op(OP_READ, 20'h00080);
    chk("end_b", 16'h0000, {15'h0000, resp.err});
    op(OP_PROTECT, 20'h00000);
    chk("sec_lock_ok", 16'h0003, {14'h0000, resp.ok, resp.prot});
    chk("slock", 16'h0001, {15'h0000, u_dev.slock});
    wr_rd("sec_lock", 20'h00010, 16'h0000, 16'hA5A5);
    op(OP_HW_RESET, 20'h00000);
    op(OP_READ, 20'h00010);
    chk("unmap", 16'hFFFF, resp.data);
    op(OP_SEC_ENTER, 20'h00000);
    op(OP_SEC_EXIT, 20'h00000);
    chk("exit", 16'h0000, {15'h0000, secure_mapped});
  endtask
  task automatic report_and_stop;
    if (error_cnt == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // main sequence after reset
  initial begin
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (3) @(posedge sys_clk);
    t_id();
    t_prot();
    t_sec();
    report_and_stop();
  end
  // watchdog well past the expected run
  initial begin
    #1000000;
    error_cnt++;
    report_and_stop();
  end
endmodule

// ---- hdl/flash_cycle.sv ----
// one asynchronous flash bus cycle, read or write, with fixed setup, pulse and hold
`timescale 1ns/10ps
module flash_cycle import flash_host_pkg::*; (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // cycle request
  input  wire logic              req,
  input  wire logic              wr,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [15:0]       wdata,
  output logic                   busy,
  output logic                   done,
  output logic [15:0]            rdata,
  // flash pins
  output bus_pins_s              pins,
  input  wire logic [15:0]       dq_in
);

  typedef enum logic [1:0] {
    C_IDLE  = 2'b00,
    C_SETUP = 2'b01,
    C_PULSE = 2'b11,
    C_HOLD  = 2'b10
  } cyc_e;

  typedef struct packed {
    cyc_e        st;
    logic [7:0]  cnt;
    logic        wr;
    logic        done;
    logic [15:0] rd;
    bus_pins_s   p;
  } cyc_s;

  localparam cyc_s CYC_RESET = '{st: C_IDLE, cnt: 8'h00, wr: 1'b0, done: 1'b0,
                                 rd: 16'h0000, p: PINS_IDLE};

  cyc_s        cyc_r;
  cyc_s        cyc_nxt;
  logic [15:0] dq_s1_r;
  logic [15:0] dq_s2_r;

  // data pins come from another timing world, so two flops first
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dq_s1_r <= 16'h0000;
      dq_s2_r <= 16'h0000;
    end else begin
      dq_s1_r <= dq_in;
      dq_s2_r <= dq_s1_r;
    end
  end

  // strobe sequence; oe and we never overlap, ce spans the whole cycle
  always_comb begin
    cyc_nxt = cyc_r;
    cyc_nxt.done = 1'b0;
    unique case (cyc_r.st)
      C_IDLE: if (req) begin
        cyc_nxt.wr = wr;
        cyc_nxt.p.addr = addr;
        cyc_nxt.p.dq = wdata;
        cyc_nxt.p.ce_n = 1'b0;
        cyc_nxt.p.dq_oe_n = !wr;
        cyc_nxt.cnt = 8'(SETUP_CYC - 1);
        cyc_nxt.st = C_SETUP;
      end
      C_SETUP: if (cyc_r.cnt == 8'h00) begin
        cyc_nxt.p.oe_n = cyc_r.wr;
        cyc_nxt.p.we_n = !cyc_r.wr;
        cyc_nxt.cnt = 8'(PULSE_CYC - 1);
        cyc_nxt.st = C_PULSE;
      end else begin
        cyc_nxt.cnt = cyc_r.cnt - 8'h01;
      end
      C_PULSE: if (cyc_r.cnt == 8'h00) begin
        // sample late in the pulse; the sync flops add two cycles of lag
        cyc_nxt.rd = dq_s2_r;
        cyc_nxt.p.oe_n = 1'b1;
        cyc_nxt.p.we_n = 1'b1;
        cyc_nxt.cnt = 8'(HOLD_CYC - 1);
        cyc_nxt.st = C_HOLD;
      end else begin
        cyc_nxt.cnt = cyc_r.cnt - 8'h01;
      end
      C_HOLD: if (cyc_r.cnt == 8'h00) begin
        cyc_nxt.p.ce_n = 1'b1;
        cyc_nxt.p.dq_oe_n = 1'b1;
        cyc_nxt.done = 1'b1;
        cyc_nxt.st = C_IDLE;
      end else begin
        cyc_nxt.cnt = cyc_r.cnt - 8'h01;
      end
    endcase
  end

  // state register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) cyc_r <= CYC_RESET;
    else cyc_r <= cyc_nxt;
  end

  // outputs
  assign busy  = (cyc_r.st != C_IDLE);
  assign done  = cyc_r.done;
  assign rdata = cyc_r.rd;
  assign pins  = cyc_r.p;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_strobe_excl;
    !(!pins.oe_n && !pins.we_n) && ((!pins.oe_n || !pins.we_n) -> !pins.ce_n);
  endproperty
  a_strobe_excl: assert property (p_strobe_excl) else $error("oe and we overlap or lack ce");

  property p_we_width;
    $fell(pins.we_n) |-> (!pins.we_n && !pins.dq_oe_n) [*8] ##1 pins.we_n;
  endproperty
  a_we_width: assert property (p_we_width) else $error("write pulse width wrong");

endmodule

// ---- hdl/flash_host.sv ----
// host controller driving a parallel flash through id, protection and secure region flows
// Operation
// - high voltage id: select by A6, A1, A0
// - identifier mode also entered by command
// - verify sector status: 00h free, 01h protected
// - protect flows use high voltage on reset only
// - protect all sectors before first unprotect
// - secure protect: enter sequence, then protect
// - exit secure region before other array access
`timescale 1ns/10ps
module flash_host import flash_host_pkg::*; #(
  parameter int unsigned       PROT_WAIT      = PROT_CYC,
  parameter int unsigned       UNPROT_WAIT    = UNPROT_CYC,
  parameter int unsigned       MAX_TRIES      = PROT_TRIES,
  parameter logic [ADDR_W-1:0] UNLK1_ADDR     = 20'h00001,
  parameter logic [15:0]       UNLK1_DATA     = 16'h0011,
  parameter logic [ADDR_W-1:0] UNLK2_ADDR     = 20'h00002,
  parameter logic [15:0]       UNLK2_DATA     = 16'h0022,
  parameter logic [ADDR_W-1:0] CMD_ADDR       = 20'h00001,
  parameter logic [15:0]       ID_CMD_DATA    = 16'h0033,
  parameter logic [15:0]       SEC_ENTER_DATA = 16'h0044,
  parameter logic [15:0]       SEC_EXIT_DATA  = 16'h0055,
  parameter logic [15:0]       RESET_DATA     = 16'h0066,
  parameter logic [15:0]       PROT_DATA      = 16'h0077,
  parameter logic [15:0]       UNPROT_DATA    = 16'h0088
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // user command port
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire cmd_s        cmd,
  input  wire logic        byte_mode,
  input  wire logic        sec_prot_hv,
  // user answer and status
  output logic             resp_valid,
  output resp_s            resp,
  output logic             secure_mapped,
  output logic             temp_unprot,
  // flash pins
  output bus_pins_s        pins,
  input  wire logic [15:0] dq_in,
  output logic             hv_select_addr_pin_en,
  output logic             reset_pin_n,
  output logic             reset_hv_en
);

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_HV   = 3'b001,
    S_SEQ  = 3'b011,
    S_CYC  = 3'b010,
    S_WAIT = 3'b110,
    S_VER  = 3'b111,
    S_SCAN = 3'b101,
    S_FIN  = 3'b100
  } st_e;

  typedef struct packed {
    st_e               st;
    op_e               op;
    logic [1:0]        sel;
    logic [ADDR_W-1:0] addr;
    logic [15:0]       data;
    logic [1:0]        idx;
    logic [7:0]        tries;
    logic [23:0]       cnt;
    logic [SECT_W-1:0] sect;
    logic              phase;
    logic              go;
    logic              hv_addr;
    logic              hv_rst;
    logic              rst_lo;
    logic              temp;
    logic              smap;
    logic              slock;
    logic              allprot;
    logic              rvalid;
    resp_s             resp;
  } host_s;

  host_s             st_r;
  host_s             st_nxt;
  logic              rst_s1_r;
  logic              rst_n_r;
  logic              cyc_wr;
  logic [ADDR_W-1:0] cyc_addr;
  logic [15:0]       cyc_wdata;
  logic              cyc_done;
  logic [15:0]       cyc_rdata;
  logic [ADDR_W-1:0] cust_end;
  logic [ADDR_W-1:0] sect_base;
  logic              refuse_rw;

  // reset release through two flops
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // secure region bounds and array access policing while the region is mapped
  assign cust_end  = byte_mode ? SEC_CUST_END_B : SEC_CUST_END_W;
  assign sect_base = {st_r.sect, {(ADDR_W - SECT_W){1'b0}}};
  assign refuse_rw = st_r.smap && ((cmd.addr > cust_end)
                     || (cmd.op == OP_WRITE && st_r.slock));

  // address and data of the pending bus cycle
  always_comb begin
    cyc_wr = 1'b0;
    cyc_addr = st_r.addr;
    cyc_wdata = st_r.data;
    unique case (st_r.st)
      S_SEQ: begin
        cyc_wr = 1'b1;
        // full unlock pair every time: no bypass or accel path to lose while mapped
        if (st_r.idx == 2'h0) begin
          cyc_addr = UNLK1_ADDR;
          cyc_wdata = UNLK1_DATA;
        end else if (st_r.idx == 2'h1) begin
          cyc_addr = UNLK2_ADDR;
          cyc_wdata = UNLK2_DATA;
        end else begin
          cyc_addr = CMD_ADDR;
          cyc_wdata = (st_r.op == OP_ID_CMD) ? ID_CMD_DATA :
                      (st_r.op == OP_SEC_ENTER) ? SEC_ENTER_DATA : SEC_EXIT_DATA;
        end
      end
      S_CYC: begin
        if (st_r.op == OP_WRITE) begin
          cyc_wr = 1'b1;
        end else if (st_r.op == OP_ID_HV || st_r.op == OP_ID_CMD) begin
          // A6 low, A1 and A0 pick the code, sector on the top bits
          cyc_addr = sect_base | ((st_r.sel == ID_DEV) ? A0_MASK :
                     (st_r.sel == ID_PROT) ? A1_MASK : 20'h00000);
          cyc_wr = st_r.phase;
          cyc_wdata = RESET_DATA;
        end else if (st_r.op == OP_PROTECT || st_r.op == OP_UNPROTECT) begin
          cyc_wr = 1'b1;
          cyc_addr = sect_base;
          cyc_wdata = (st_r.op == OP_UNPROTECT && st_r.phase) ? UNPROT_DATA : PROT_DATA;
        end
      end
      S_VER, S_SCAN: cyc_addr = sect_base | A1_MASK;
      default: ;
    endcase
  end

  // sequencing of all operations
  always_comb begin
    logic adv;
    adv = 1'b0;
    st_nxt = st_r;
    st_nxt.go = 1'b0;
    st_nxt.rvalid = 1'b0;
    unique case (st_r.st)
      S_IDLE: if (cmd_valid) begin
        st_nxt.op = cmd.op;
        st_nxt.sel = cmd.sel;
        st_nxt.addr = cmd.addr;
        st_nxt.data = cmd.data;
        st_nxt.sect = cmd.addr[ADDR_W-1 -: SECT_W];
        st_nxt.idx = 2'h0;
        st_nxt.tries = 8'h00;
        st_nxt.phase = 1'b0;
        st_nxt.allprot = 1'b0;
        st_nxt.resp = '0;
        st_nxt.cnt = 24'(HV_CYC);
        st_nxt.st = S_HV;
        unique case (cmd.op)
          OP_READ, OP_WRITE: if (refuse_rw) begin
            st_nxt.resp.err = 1'b1;
            st_nxt.cnt = 24'h000000;
            st_nxt.st = S_FIN;
          end else begin
            st_nxt.go = 1'b1;
            st_nxt.st = S_CYC;
          end
          OP_ID_HV: st_nxt.hv_addr = 1'b1;
          OP_ID_CMD, OP_SEC_ENTER, OP_SEC_EXIT: begin
            st_nxt.go = 1'b1;
            st_nxt.st = S_SEQ;
          end
          // secure region may be protected with the reset pin at normal high
          OP_PROTECT: st_nxt.hv_rst = !st_r.smap || sec_prot_hv || st_r.temp;
          OP_UNPROTECT: if (st_r.smap) begin
            st_nxt.resp.err = 1'b1;
            st_nxt.cnt = 24'h000000;
            st_nxt.st = S_FIN;
          end else begin
            st_nxt.hv_rst = 1'b1;
          end
          OP_TEMP_ON: begin
            st_nxt.hv_rst = 1'b1;
            st_nxt.temp = 1'b1;
          end
          OP_TEMP_OFF: begin
            st_nxt.temp = 1'b0;
            st_nxt.st = S_FIN;
          end
          OP_HW_RESET: begin
            st_nxt.rst_lo = 1'b1;
            st_nxt.smap = 1'b0;
            st_nxt.cnt = 24'(RST_CYC);
            st_nxt.st = S_FIN;
          end
          default: begin
            st_nxt.resp.err = 1'b1;
            st_nxt.st = S_FIN;
          end
        endcase
      end
      S_HV: if (st_r.cnt == 24'h000000) begin
        st_nxt.go = 1'b1;
        if (st_r.op == OP_UNPROTECT) begin
          st_nxt.sect = '0;
          st_nxt.st = S_SCAN;
        end else if (st_r.op == OP_ID_HV || st_r.op == OP_PROTECT) begin
          st_nxt.st = S_CYC;
        end else begin
          st_nxt.go = 1'b0;
          st_nxt.resp.ok = 1'b1;
          st_nxt.st = S_FIN;
        end
      end else begin
        st_nxt.cnt = st_r.cnt - 24'h000001;
      end
      S_SEQ: if (cyc_done) begin
        st_nxt.go = 1'b1;
        st_nxt.idx = st_r.idx + 2'h1;
        if (st_r.idx == 2'h2) begin
          st_nxt.go = (st_r.op == OP_ID_CMD);
          st_nxt.st = (st_r.op == OP_ID_CMD) ? S_CYC : S_FIN;
          st_nxt.resp.ok = (st_r.op != OP_ID_CMD);
          st_nxt.cnt = 24'h000000;
          st_nxt.smap = (st_r.op == OP_SEC_ENTER);
        end
      end
      S_CYC: if (cyc_done) begin
        st_nxt.cnt = 24'h000000;
        st_nxt.st = S_FIN;
        if (st_r.op == OP_PROTECT || st_r.op == OP_UNPROTECT) begin
          st_nxt.cnt = (st_r.op == OP_UNPROTECT && st_r.phase) ? 24'(UNPROT_WAIT) : 24'(PROT_WAIT);
          st_nxt.st = S_WAIT;
        end else if (st_r.op == OP_ID_CMD && st_r.phase) begin
          st_nxt.resp.ok = 1'b1;  // reset command written, array mode again
        end else begin
          st_nxt.resp.data = cyc_rdata;
          st_nxt.resp.prot = cyc_rdata[PROT_BIT];
          st_nxt.resp.lock = cyc_rdata[LOCK_BIT];
          st_nxt.resp.ok = (st_r.op != OP_ID_CMD);
          if (st_r.op == OP_ID_CMD) begin
            st_nxt.phase = 1'b1;
            st_nxt.go = 1'b1;
            st_nxt.st = S_CYC;
          end else if (st_r.op == OP_ID_HV) begin
            st_nxt.hv_addr = 1'b0;
            st_nxt.cnt = 24'(HV_CYC);
          end
        end
      end
      S_WAIT: if (st_r.cnt == 24'h000000) begin
        st_nxt.go = 1'b1;
        st_nxt.st = S_VER;
      end else begin
        st_nxt.cnt = st_r.cnt - 24'h000001;
      end
      S_VER: if (cyc_done) begin
        if (cyc_rdata[PROT_BIT] == !(st_r.op == OP_UNPROTECT && st_r.phase)) begin
          if (st_r.op == OP_UNPROTECT && !st_r.phase) begin
            adv = 1'b1;
          end else begin
            st_nxt.resp.ok = 1'b1;
            st_nxt.resp.prot = cyc_rdata[PROT_BIT];
            st_nxt.slock = st_r.slock || st_r.smap;
            st_nxt.cnt = 24'(HV_CYC);
            st_nxt.st = S_FIN;
          end
        end else if (st_r.tries == 8'(MAX_TRIES - 1)) begin
          st_nxt.resp.err = 1'b1;
          st_nxt.cnt = 24'(HV_CYC);
          st_nxt.st = S_FIN;
        end else begin
          st_nxt.tries = st_r.tries + 8'h01;
          st_nxt.go = 1'b1;
          st_nxt.st = S_CYC;
        end
      end
      S_SCAN: if (cyc_done) begin
        if (cyc_rdata[PROT_BIT]) begin
          adv = 1'b1;
        end else begin
          st_nxt.tries = 8'h00;  // still free: protect it first
          st_nxt.go = 1'b1;
          st_nxt.st = S_CYC;
        end
      end
      S_FIN: begin
        // high voltage off, except while temporary unprotect is held
        st_nxt.hv_addr = 1'b0;
        st_nxt.hv_rst = st_r.temp;
        if (st_r.cnt == 24'h000000) begin
          st_nxt.rst_lo = 1'b0;
          st_nxt.rvalid = 1'b1;
          st_nxt.st = S_IDLE;
        end else begin
          st_nxt.cnt = st_r.cnt - 24'h000001;
        end
      end
    endcase
    // walk every sector-address combination before the unprotect write
    if (adv) begin
      st_nxt.go = 1'b1;
      if (st_r.sect == {SECT_W{1'b1}}) begin
        st_nxt.allprot = 1'b1;
        st_nxt.phase = 1'b1;
        st_nxt.tries = 8'h00;
        st_nxt.sect = st_r.addr[ADDR_W-1 -: SECT_W];
        st_nxt.st = S_CYC;
      end else begin
        st_nxt.sect = st_r.sect + 8'h01;
        st_nxt.st = S_SCAN;
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) st_r <= '0;
    else st_r <= st_nxt;
  end

  flash_cycle u_cycle (
    .sys_clk (sys_clk),
    .rst_n   (rst_n_r),
    .req     (st_r.go),
    .wr      (cyc_wr),
    .addr    (cyc_addr),
    .wdata   (cyc_wdata),
    .busy    (),
    .done    (cyc_done),
    .rdata   (cyc_rdata),
    .pins    (pins),
    .dq_in   (dq_in)
  );

  // outputs
  assign cmd_ready             = (st_r.st == S_IDLE);
  assign resp_valid            = st_r.rvalid;
  assign resp                  = st_r.resp;
  assign secure_mapped         = st_r.smap;
  assign temp_unprot           = st_r.temp;
  assign hv_select_addr_pin_en = st_r.hv_addr;
  assign reset_pin_n           = !st_r.rst_lo;
  assign reset_hv_en           = st_r.hv_rst && !st_r.rst_lo;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n_r);

  property p_id_hv_addr;
    (st_r.go && st_r.st == S_CYC && st_r.op == OP_ID_HV)
      |-> (hv_select_addr_pin_en && !cyc_addr[A6_POS] && !cyc_wr);
  endproperty
  a_id_hv_addr: assert property (p_id_hv_addr) else $error("bad hv id address");

  property p_id_cmd_no_hv;
    (st_r.op == OP_ID_CMD && st_r.st != S_IDLE) |-> !hv_select_addr_pin_en;
  endproperty
  a_id_cmd_no_hv: assert property (p_id_cmd_no_hv) else $error("hv during cmd id");

  property p_ver_sect;
    (st_r.go && (st_r.st == S_VER || st_r.st == S_SCAN))
      |-> (cyc_addr[ADDR_W-1 -: SECT_W] == st_r.sect && cyc_addr[1] && !cyc_wr);
  endproperty
  a_ver_sect: assert property (p_ver_sect) else $error("verify address wrong");

  property p_prot_hv;
    (st_r.st == S_WAIT) |-> (!hv_select_addr_pin_en && reset_pin_n);
  endproperty
  a_prot_hv: assert property (p_prot_hv) else $error("protect uses address hv");

  property p_unprot_after_all;
    (st_r.go && st_r.st == S_CYC && cyc_wdata == UNPROT_DATA && st_r.op == OP_UNPROTECT)
      |-> (st_r.allprot && st_r.phase);
  endproperty
  a_unprot_after_all: assert property (p_unprot_after_all) else $error("early unprotect");

  sequence s_enter_req;
    st_r.st == S_IDLE && cmd_valid && cmd.op == OP_SEC_ENTER;
  endsequence
  sequence s_mapped_done;
    resp_valid && resp.ok && secure_mapped;
  endsequence
  property p_enter_maps;
    s_enter_req |-> ##[1:200] s_mapped_done;
  endproperty
  a_enter_maps: assert property (p_enter_maps) else $error("enter did not map region");

  property p_map_confined;
    (secure_mapped && st_r.go && st_r.st == S_CYC && (st_r.op == OP_READ || st_r.op == OP_WRITE))
      |-> (cyc_addr <= cust_end);
  endproperty
  a_map_confined: assert property (p_map_confined) else $error("array access while mapped");

  property p_unlock_first;
    (st_r.go && st_r.st == S_SEQ && st_r.idx == 2'h0)
      |-> (cyc_wr && cyc_addr == UNLK1_ADDR && cyc_wdata == UNLK1_DATA);
  endproperty
  a_unlock_first: assert property (p_unlock_first) else $error("bad first unlock cycle");

  property p_reset_unmaps;
    (st_r.st == S_IDLE && cmd_valid && cmd.op == OP_HW_RESET)
      |=> (!secure_mapped && !reset_pin_n && !reset_hv_en);
  endproperty
  a_reset_unmaps: assert property (p_reset_unmaps) else $error("reset left region mapped");

endmodule

// ---- hdl/flash_host_pkg.sv ----
// shared constants, types and pin bundles for the flash identification and protection host
package flash_host_pkg;

  // address and field layout
  localparam int ADDR_W = 20;
  localparam int SECT_W = 8;
  localparam int A6_POS = 6;
  localparam logic [19:0] A1_MASK = 20'h00002;
  localparam logic [19:0] A0_MASK = 20'h00001;
  localparam int PROT_BIT = 0;
  localparam int LOCK_BIT = 7;

  // secure region layout, word and byte mode
  localparam logic [19:0] SEC_SN_END_W   = 20'h00007;
  localparam logic [19:0] SEC_CUST_END_W = 20'h0007F;
  localparam logic [19:0] SEC_SN_END_B   = 20'h0000F;
  localparam logic [19:0] SEC_CUST_END_B = 20'h000FF;

  // identifier select codes
  localparam logic [1:0] ID_MFR  = 2'h0;
  localparam logic [1:0] ID_DEV  = 2'h1;
  localparam logic [1:0] ID_PROT = 2'h2;

  // timing, in ns or us as named, then in sys_clk cycles
  localparam int CLK_NS      = 10;
  localparam int T_SETUP_NS  = 30;
  localparam int T_PULSE_NS  = 80;
  localparam int T_HOLD_NS   = 30;
  localparam int T_HV_NS     = 4000;
  localparam int T_RST_NS    = 500;
  localparam int T_PROT_US   = 150;
  localparam int T_UNPROT_US = 15000;
  localparam int SETUP_CYC   = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_CYC   = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC    = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int HV_CYC      = (T_HV_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_CYC     = (T_RST_NS + CLK_NS - 1) / CLK_NS;
  localparam int PROT_CYC    = (T_PROT_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int UNPROT_CYC  = (T_UNPROT_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int PROT_TRIES  = 25;

  // user operations
  typedef enum logic [3:0] {
    OP_READ      = 4'h0,
    OP_WRITE     = 4'h1,
    OP_ID_HV     = 4'h2,
    OP_ID_CMD    = 4'h3,
    OP_SEC_ENTER = 4'h4,
    OP_SEC_EXIT  = 4'h5,
    OP_PROTECT   = 4'h6,
    OP_UNPROTECT = 4'h7,
    OP_TEMP_ON   = 4'h8,
    OP_TEMP_OFF  = 4'h9,
    OP_HW_RESET  = 4'hA
  } op_e;

  typedef struct packed {
    op_e              op;
    logic [1:0]       sel;
    logic [ADDR_W-1:0] addr;
    logic [15:0]      data;
  } cmd_s;

  typedef struct packed {
    logic        ok;
    logic        err;
    logic        prot;
    logic        lock;
    logic [15:0] data;
  } resp_s;

  typedef struct packed {
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic [ADDR_W-1:0] addr;
    logic [15:0]       dq;
    logic              dq_oe_n;
  } bus_pins_s;

  localparam bus_pins_s PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                                      addr: 20'h00000, dq: 16'h0000, dq_oe_n: 1'b1};

endpackage
